// *** logic/dbw_pkg.sv ***
// shared constants, codes, link bundle and register map of the ddr3 burst link
package dbw_pkg;

  // ************************************************************
  // latencies in ck cycles
  // ************************************************************
  localparam int unsigned CL        = 5;          // cas latency
  localparam int unsigned CWL       = 5;          // cas write latency
  localparam int unsigned AL        = 0;          // additive latency
  localparam int unsigned RL        = AL + CL;    // read latency
  localparam int unsigned WL        = AL + CWL;   // write latency
  localparam int unsigned BL8_BEATS = 8;          // full burst slot
  localparam int unsigned BC4_BEATS = 4;          // chopped burst

  // timeline points, 8-bit ck cycle count from the column command
  localparam logic [7:0] TL_WL   = 8'(WL);
  localparam logic [7:0] TL_RL   = 8'(RL);
  localparam logic [7:0] TL_SLOT = 8'(WL + BL8_BEATS);
  localparam logic [7:0] TL_BL8  = 8'(BL8_BEATS);
  localparam logic [7:0] TL_BC4  = 8'(BC4_BEATS);

  // ************************************************************
  // timing counts in ck cycles
  // ************************************************************
  localparam logic [3:0] TWTR_CK = 4'h4;          // write to read delay
  localparam logic [3:0] TWR_CK  = 4'h8;          // write recovery
  localparam logic [3:0] ODTH4   = 4'h4;          // odt hold, four beats
  localparam logic [3:0] ODTH8   = 4'h6;          // odt hold, eight beats
  localparam logic [3:0] T_ANPD  = 4'(WL - 1);    // termination transition
  localparam int unsigned CK_DIV_W = 3;           // ck period is 2**3 pclk

  // ************************************************************
  // command codes {ras_n, cas_n, we_n} and control ops
  // ************************************************************
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR  = 3'h4;
  localparam logic [2:0] CMD_RD  = 3'h5;
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [3:0] OP_PDE  = 4'h8;          // power-down entry
  localparam logic [3:0] OP_PDX  = 4'h9;          // power-down exit

  // mode register 0 burst field codes and address bits
  localparam logic [1:0] BL_FIX8 = 2'h0;
  localparam logic [1:0] BL_OTF  = 2'h1;
  localparam logic [1:0] BL_FIX4 = 2'h2;
  localparam logic [2:0] MR0_BA  = 3'h0;
  localparam int unsigned A12_BIT = 12;
  localparam int unsigned A10_BIT = 10;

  // ************************************************************
  // controller register map and fields
  // ************************************************************
  localparam logic [11:0] REG_CMD    = 12'h000;
  localparam logic [11:0] REG_WDATA  = 12'h004;
  localparam logic [11:0] REG_CTRL   = 12'h008;
  localparam logic [11:0] REG_STATUS = 12'h00C;
  localparam logic [11:0] REG_RDATA  = 12'h010;
  localparam int unsigned ST_BUSY  = 0;
  localparam int unsigned ST_PDERR = 1;
  localparam int unsigned ST_PD    = 2;
  localparam int unsigned ST_CHOP  = 3;

  // link pins as seen by the device synchroniser
  typedef struct packed {
    logic        ck;
    logic        cke;
    logic        cs_n;
    logic [2:0]  cmd;
    logic [2:0]  ba;
    logic [15:0] addr;
    logic        odt;
    logic [15:0] dq;
  } dbw_lnk_t;

  // burst chop decision from the mode field and a12
  function automatic logic dbw_is_chop(input logic [1:0] bl, input logic a12);
    dbw_is_chop = (bl == BL_FIX4) || ((bl == BL_OTF) && !a12);
  endfunction : dbw_is_chop

endpackage : dbw_pkg

// *** logic/dbw_link_if.sv ***
// link between the controller end and the dram end
`timescale 1ns/1ps
`default_nettype none
interface dbw_link_if;
  logic        ck;          // link clock, made by controller
  logic        cke;         // clock enable, low in power-down
  logic        cs_n;        // chip select, active low
  logic [2:0]  cmd;         // {ras_n, cas_n, we_n}
  logic [2:0]  ba;          // bank address
  logic [15:0] addr;        // row / column / mode address
  logic        odt;         // on-die termination request
  logic [15:0] ctl_dq;      // controller data out
  logic        ctl_dq_oe;   // controller drives dq
  logic [15:0] dev_dq;      // device data out
  logic        dev_dq_oe;   // device drives dq
  logic [15:0] dq;          // resolved data wire

  // resolved level of the shared data wire
  assign dq = ctl_dq_oe ? ctl_dq : (dev_dq_oe ? dev_dq : 16'h0000);

  modport ctl (output ck, cke, cs_n, cmd, ba, addr, odt, ctl_dq, ctl_dq_oe,
               input dq);
  modport dev (input ck, cke, cs_n, cmd, ba, addr, odt, dq,
               output dev_dq, dev_dq_oe);
endinterface : dbw_link_if
`default_nettype wire

// *** logic/dbw_dev.sv ***
// dram end: command decode, burst length, write capture, read return
`timescale 1ns/1ps
`default_nettype none
module dbw_dev (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // link
  dbw_link_if.dev          lnk,
  // user side
  output logic             wr_beat,     // one write beat captured
  output logic [15:0]      wr_data,     // captured beat
  output logic             last_chop,   // last column burst was chopped
  output logic             term_on,     // termination requested
  output logic             term_async   // termination in asynchronous mode
);

  // state machine of the dram end
  typedef struct packed {
    dbw_pkg::dbw_lnk_t s1;           // first synchroniser stage
    dbw_pkg::dbw_lnk_t s2;           // second synchroniser stage
    logic              ckp;          // ck of the previous sample
    logic              cke_r;        // cke as last registered
    logic [1:0]        mr0_bl;       // burst length field
    logic [7:0]        tl;           // ck cycles since column command
    logic              col;          // column burst in progress
    logic              wr;           // burst is a write
    logic              chop;         // burst is four beats
    logic [15:0]       dq;           // read data out
    logic              dq_oe;        // read data enable
    logic [7:0][15:0]  mem;          // beat store
    logic [3:0]        anpd;         // transition countdown
    logic              term_async;
    logic              term_on;
    logic              wr_beat;
    logic [15:0]       wr_data;
  } dbw_ds_t;

  dbw_ds_t     r;                    // registered state
  dbw_ds_t     n;                    // next state
  logic [7:0]  nt;                   // timeline after this rise
  logic [7:0]  len;                  // beats of this burst
  logic [7:0]  wi;                   // write beat index
  logic [7:0]  ri;                   // read beat index

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    n         = r;
    nt        = r.tl + 8'h01;
    len       = r.chop ? dbw_pkg::TL_BC4 : dbw_pkg::TL_BL8;
    wi        = nt - dbw_pkg::TL_WL;
    ri        = nt - dbw_pkg::TL_RL;
    // two-stage synchroniser of every link pin
    n.s1      = {lnk.ck, lnk.cke, lnk.cs_n, lnk.cmd, lnk.ba, lnk.addr, lnk.odt, lnk.dq};
    n.s2      = r.s1;
    n.ckp     = r.s2.ck;
    n.wr_beat = 1'b0;
    // work only on a ck rising edge
    if (r.s2.ck && !r.ckp)
    begin
      n.cke_r   = r.s2.cke;
      n.term_on = r.s2.odt && r.s2.cke;
      // termination mode follows cke after the transition period
      if (r.s2.cke != r.cke_r)
        n.anpd = dbw_pkg::T_ANPD;
      else if (r.anpd != 4'h0)
        n.anpd = r.anpd - 4'h1;
      if (r.anpd == 4'h1)
        n.term_async = !r.cke_r;
      if (r.s2.cke && !r.s2.cs_n && r.s2.cmd == dbw_pkg::CMD_MRS)
      begin
        // mode register 0 keeps the burst field
        if (r.s2.ba == dbw_pkg::MR0_BA)
          n.mr0_bl = r.s2.addr[1:0];
      end
      else if (r.s2.cke && !r.s2.cs_n &&
               (r.s2.cmd == dbw_pkg::CMD_WR || r.s2.cmd == dbw_pkg::CMD_RD))
      begin
        // each column command takes its own length
        n.col  = 1'b1;
        n.wr   = (r.s2.cmd == dbw_pkg::CMD_WR);
        n.chop = dbw_pkg::dbw_is_chop(r.mr0_bl, r.s2.addr[dbw_pkg::A12_BIT]);
        n.tl   = 8'h00;
      end
      else if (r.col)
      begin
        n.tl = nt;
        if (r.wr)
        begin
          // capture beats from write latency on
          if (nt >= dbw_pkg::TL_WL && wi < len)
          begin
            n.mem[wi[2:0]] = r.s2.dq;
            n.wr_beat      = 1'b1;
            n.wr_data      = r.s2.dq;
          end
          // a chopped write still holds the full slot
          if (nt == dbw_pkg::TL_SLOT)
            n.col = 1'b0;
        end
        else
        begin
          // return beats from read latency on
          if (nt >= dbw_pkg::TL_RL && ri < len)
          begin
            n.dq    = r.mem[ri[2:0]];
            n.dq_oe = 1'b1;
          end
          else if (ri == len)
          begin
            n.dq_oe = 1'b0;
            n.col   = 1'b0;
          end
        end
      end
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= '0;
    else
      r <= n;
  end

  // outputs straight from state
  assign lnk.dev_dq    = r.dq;
  assign lnk.dev_dq_oe = r.dq_oe;
  assign wr_beat       = r.wr_beat;
  assign wr_data       = r.wr_data;
  assign last_chop     = r.chop;
  assign term_on       = r.term_on;
  assign term_async    = r.term_async;

endmodule : dbw_dev
`default_nettype wire

// *** logic/dbw_ctl.sv ***
// controller end: apb command port, ck divider and link timing guards
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dbw_ctl (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // link
  dbw_link_if.ctl          lnk
);

  // command sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,                // no order pending
    ST_WAIT = 3'b010,                // order waits for its timing
    ST_DATA = 3'b100                 // command out, data phase running
  } dbw_cst_t;

  // whole state of the controller end
  typedef struct packed {
    dbw_cst_t                      st;
    logic [dbw_pkg::CK_DIV_W-1:0]  div;       // ck divider
    logic                          cke;
    logic                          cs_n;
    logic [2:0]                    cmd;
    logic [2:0]                    ba;
    logic [15:0]                   addr;
    logic                          odt;       // odt pin
    logic                          odt_reg;   // odt at last rise
    logic [15:0]                   dq;
    logic                          dq_oe;
    logic [15:0]                   dq_s1;     // read data sync stage 1
    logic [15:0]                   dq_s2;     // read data sync stage 2
    logic [3:0]                    op;        // pending order
    logic [2:0]                    op_ba;
    logic [15:0]                   op_addr;
    logic                          col;       // order is a column burst
    logic                          wr;        // order is a write
    logic                          chop;      // burst is four beats
    logic [7:0]                    tl;        // ck cycles since command
    logic [1:0]                    mr0_bl;    // burst field last set
    logic [7:0]                    bank_open; // open bank map
    logic [3:0]                    wtr;       // write to read countdown
    logic [3:0]                    wrc;       // write recovery countdown
    logic [3:0]                    hold;      // odt hold countdown
    logic                          odt_req;
    logic                          pd_err;
    logic [31:0]                   wdata;
    logic [31:0]                   rdata;
    logic [31:0]                   prdata;
  } dbw_cs_t;

  localparam logic [dbw_pkg::CK_DIV_W-1:0] DIV_RISE = {1'b0, {(dbw_pkg::CK_DIV_W-1){1'b1}}};
  localparam logic [dbw_pkg::CK_DIV_W-1:0] DIV_FALL = {dbw_pkg::CK_DIV_W{1'b1}};

  dbw_cs_t     r;                    // registered state
  dbw_cs_t     n;                    // next state
  logic        rise;                 // ck rises at this edge
  logic        fall;                 // ck falls at this edge
  logic [7:0]  nt;                   // timeline after next rise
  logic [7:0]  len;                  // beats of this burst
  logic [7:0]  wi;                   // write beat index
  logic [3:0]  hd;                   // odt hold being worked out
  logic [3:0]  whd;                  // hold due to a write
  logic        mapped;               // address hits a register
  logic        wr_cmd;               // write on the pins now

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    n       = r;
    rise    = (r.div == DIV_RISE);
    fall    = (r.div == DIV_FALL);
    nt      = r.tl + 8'h01;
    len     = r.chop ? dbw_pkg::TL_BC4 : dbw_pkg::TL_BL8;
    wi      = nt - dbw_pkg::TL_WL;
    wr_cmd  = !r.cs_n && r.cke && (r.cmd == dbw_pkg::CMD_WR);
    whd     = r.chop ? dbw_pkg::ODTH4 : dbw_pkg::ODTH8;
    hd      = (r.hold != 4'h0) ? r.hold - 4'h1 : 4'h0;
    mapped  = (paddr == dbw_pkg::REG_CMD) || (paddr == dbw_pkg::REG_WDATA) ||
              (paddr == dbw_pkg::REG_CTRL) || (paddr == dbw_pkg::REG_STATUS) ||
              (paddr == dbw_pkg::REG_RDATA);
    n.div   = r.div + 1'b1;
    n.dq_s1 = lnk.dq;
    n.dq_s2 = r.dq_s1;
    // bookkeeping at the rise that registers the pins
    if (rise)
    begin
      n.odt_reg = r.odt;
      if (r.odt && !r.odt_reg && hd < dbw_pkg::ODTH4)
        hd = dbw_pkg::ODTH4;
      if (wr_cmd && r.odt && hd < whd)
        hd = whd;
      n.hold = hd;
      n.wtr  = (r.wtr != 4'h0) ? r.wtr - 4'h1 : 4'h0;
      n.wrc  = (r.wrc != 4'h0) ? r.wrc - 4'h1 : 4'h0;
      if (r.st == ST_DATA)
      begin
        n.tl = nt;
        if (!r.col && nt == 8'h00)
          n.st = ST_IDLE;
        else if (r.col && r.wr && nt == dbw_pkg::TL_SLOT)
        begin
          // both intervals start at the end of the full slot
          n.wtr = dbw_pkg::TWTR_CK;
          n.wrc = dbw_pkg::TWR_CK;
          n.st  = ST_IDLE;
        end
        else if (r.col && !r.wr)
        begin
          // keep the first two returned beats
          if (r.tl == dbw_pkg::TL_RL)
            n.rdata[15:0] = r.dq_s2;
          if (r.tl == dbw_pkg::TL_RL + 8'h01)
            n.rdata[31:16] = r.dq_s2;
          if (r.tl == dbw_pkg::TL_RL + len)
            n.st = ST_IDLE;
        end
      end
    end
    // pins change while ck falls
    if (fall)
    begin
      n.cs_n  = 1'b1;
      n.cmd   = dbw_pkg::CMD_NOP;
      n.dq_oe = 1'b0;
      n.odt   = r.odt_req || (r.hold > 4'h1);
      // write beats from write latency on
      if (r.st == ST_DATA && r.col && r.wr && nt >= dbw_pkg::TL_WL && wi < len)
      begin
        n.dq_oe = 1'b1;
        n.dq    = wi[0] ? r.wdata[31:16] : r.wdata[15:0];
      end
      if (r.st == ST_WAIT)
      begin
        if (r.op == dbw_pkg::OP_PDE)
        begin
          // entry cycle carries nop and needs an open bank
          n.pd_err = !(|r.bank_open) || !r.cke;
          n.cke    = !((|r.bank_open) && r.cke) && r.cke;
          n.st     = ST_IDLE;
        end
        else if (r.op == dbw_pkg::OP_PDX)
        begin
          n.cke = 1'b1;
          n.st  = ST_IDLE;
        end
        else if (!r.cke || r.op[3])
        begin
          // no command while powered down
          n.pd_err = 1'b1;
          n.st     = ST_IDLE;
        end
        else if (!(r.op[2:0] == dbw_pkg::CMD_RD && r.wtr != 4'h0) &&
                 !(r.op[2:0] == dbw_pkg::CMD_PRE && r.wrc != 4'h0))
        begin
          n.cs_n = 1'b0;
          n.cmd  = r.op[2:0];
          n.ba   = r.op_ba;
          n.addr = r.op_addr;
          n.tl   = 8'hFF;
          n.st   = ST_DATA;
          n.col  = (r.op[2:0] == dbw_pkg::CMD_WR) || (r.op[2:0] == dbw_pkg::CMD_RD);
          n.wr   = (r.op[2:0] == dbw_pkg::CMD_WR);
          // only a column command changes the last burst length
          if (n.col)
            n.chop = dbw_pkg::dbw_is_chop(r.mr0_bl, r.op_addr[dbw_pkg::A12_BIT]);
          if (r.op[2:0] == dbw_pkg::CMD_MRS && r.op_ba == dbw_pkg::MR0_BA)
            n.mr0_bl = r.op_addr[1:0];
          if (r.op[2:0] == dbw_pkg::CMD_ACT)
            n.bank_open[r.op_ba] = 1'b1;
          if (r.op[2:0] == dbw_pkg::CMD_PRE && r.op_addr[dbw_pkg::A10_BIT])
            n.bank_open = 8'h00;
          else if (r.op[2:0] == dbw_pkg::CMD_PRE)
            n.bank_open[r.op_ba] = 1'b0;
        end
      end
    end
    // apb read data latched in the setup cycle
    if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        dbw_pkg::REG_CMD:    n.prdata = {r.op_addr, 9'h000, r.op_ba, r.op};
        dbw_pkg::REG_WDATA:  n.prdata = r.wdata;
        dbw_pkg::REG_CTRL:   n.prdata = {31'h00000000, r.odt_req};
        dbw_pkg::REG_STATUS: n.prdata = {28'h0000000, r.chop, !r.cke, r.pd_err,
                                         r.st != ST_IDLE};
        dbw_pkg::REG_RDATA:  n.prdata = r.rdata;
        default:             n.prdata = 32'h00000000;
      endcase
    end
    // apb writes take effect in the access cycle
    if (psel && penable && pwrite)
    begin
      if (paddr == dbw_pkg::REG_CMD && r.st == ST_IDLE)
      begin
        n.op      = pwdata[3:0];
        n.op_ba   = pwdata[6:4];
        n.op_addr = pwdata[31:16];
        n.st      = ST_WAIT;
      end
      if (paddr == dbw_pkg::REG_WDATA)
        n.wdata = pwdata;
      if (paddr == dbw_pkg::REG_CTRL)
        n.odt_req = pwdata[0];
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r         <= '0;
      r.st      <= ST_IDLE;
      r.cs_n    <= 1'b1;
      r.cke     <= 1'b1;
      r.cmd     <= dbw_pkg::CMD_NOP;
    end
    else
      r <= n;
  end

  // outputs from state, pslverr decoded from the bus; zero-wait apb
  assign lnk.ck        = r.div[dbw_pkg::CK_DIV_W-1];
  assign lnk.cke       = r.cke;
  assign lnk.cs_n      = r.cs_n;
  assign lnk.cmd       = r.cmd;
  assign lnk.ba        = r.ba;
  assign lnk.addr      = r.addr;
  assign lnk.odt       = r.odt;
  assign lnk.ctl_dq    = r.dq;
  assign lnk.ctl_dq_oe = r.dq_oe;
  assign prdata        = r.prdata;
  assign pready        = 1'b1;
  assign pslverr       = psel && penable && !mapped;

endmodule : dbw_ctl
`default_nettype wire

// *** bench/dbw_link_properties.sv ***
// link timing checker for the ddr3 burst link
`timescale 1ns/1ps
`default_nettype none
module dbw_link_props (
  // link clock and reset
  input  wire logic        ck,
  input  wire logic        presetn,
  // command side
  input  wire logic        cke,
  input  wire logic        cs_n,
  input  wire logic [2:0]  cmd,
  input  wire logic [2:0]  ba,
  input  wire logic [15:0] addr,
  input  wire logic        odt,
  // data enables
  input  wire logic        ctl_dq_oe,
  input  wire logic        dev_dq_oe
);
  // ************************************************************
  // command decode and burst field tracking
  // ************************************************************
  logic [1:0] mode;                                      // last burst field
  wire go  = cke && !cs_n;                               // command registered
  wire wr  = go && (cmd == dbw_pkg::CMD_WR);             // write seen
  wire rd  = go && (cmd == dbw_pkg::CMD_RD);             // read seen
  wire pre = go && (cmd == dbw_pkg::CMD_PRE);            // precharge seen
  wire chp = (mode == 2'h2) || ((mode == 2'h1) && !addr[12]);  // chopped burst
  // follow writes of the burst field
  always_ff @(posedge ck or negedge presetn)
    if (!presetn)
      mode <= 2'h0;
    else if (go && (cmd == dbw_pkg::CMD_MRS) && (ba == 3'h0))
      mode <= addr[1:0];
  default clocking @(posedge ck); endclocking
  default disable iff (!presetn);
  // beat windows after a column command
  sequence s_wlat; ##1 (!ctl_dq_oe)[*4] ##1 ctl_dq_oe[*4]; endsequence
  sequence s_rlat; ##1 (!dev_dq_oe)[*5] ##1 dev_dq_oe[*4]; endsequence
  // ************************************************************
  // assertions
  // ************************************************************
  AST_WR_BC4: assert property (wr && chp |-> s_wlat ##1 !ctl_dq_oe)
    else $error("chopped write beat window wrong");
  AST_WR_BL8: assert property (wr && !chp |-> s_wlat ##1 ctl_dq_oe[*4] ##1 !ctl_dq_oe)
    else $error("eight beat write window wrong");
  AST_RD_BC4: assert property (rd && chp |-> s_rlat ##1 !dev_dq_oe)
    else $error("chopped read beat window wrong");
  AST_RD_BL8: assert property (rd && !chp |-> s_rlat ##1 dev_dq_oe[*4] ##1 !dev_dq_oe)
    else $error("eight beat read window wrong");
  AST_WTR_BL8: assert property (wr && !chp |-> ##1 (!rd)[*8] ##1 (!rd)[*8])
    else $error("read too soon after write");
  AST_WTR_BC4: assert property (wr && chp |-> ##1 (!rd)[*8] ##1 (!rd)[*8])
    else $error("read too soon after chopped write");
  AST_TWR: assert property (wr |-> ##1 (!pre)[*8] ##1 (!pre)[*8] ##1 (!pre)[*4])
    else $error("precharge too soon after write");
  AST_ODT_H4: assert property ($rose(odt) |-> odt[*4])
    else $error("termination dropped early");
  AST_ODT_WR8: assert property (wr && odt && !chp |-> odt[*6])
    else $error("termination hold after write too short");
  AST_ODT_WR4: assert property (wr && odt && chp |-> odt[*4])
    else $error("termination hold after chopped write too short");
  AST_PDE: assert property ($fell(cke) |-> cs_n || (cmd == dbw_pkg::CMD_NOP))
    else $error("power-down entry with a command");
endmodule : dbw_link_props
`default_nettype wire

// *** bench/testbench.sv ***
// self-checking bench for both ends of the ddr3 burst link
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ************************************************************
  // signals
  // ************************************************************
  logic        pclk = 1'h0;                  // apb clock
  logic        presetn = 1'h0;               // reset, active low
  logic        psel = 1'h0;                  // apb request
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, wd;
  logic        pready, pslverr, err, wr_beat, last_chop, term_on, term_async;
  logic [15:0] wr_data;
  logic [1:0]  m;                            // burst field under test
  logic        a12, r12, o, ch, rc;
  int          num_errors = 0;
  int          comparisons = 0;
  int          beats = 0;                    // write beats seen
  dbw_link_if lnk ();
  dbw_ctl i_dbw_ctl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lnk(lnk.ctl));
  dbw_dev i_dbw_dev (.pclk(pclk), .presetn(presetn), .lnk(lnk.dev), .wr_beat(wr_beat),
    .wr_data(wr_data), .last_chop(last_chop), .term_on(term_on), .term_async(term_async));
  dbw_link_props i_dbw_link_props (.ck(lnk.ck), .presetn(presetn), .cke(lnk.cke),
    .cs_n(lnk.cs_n), .cmd(lnk.cmd), .ba(lnk.ba), .addr(lnk.addr), .odt(lnk.odt),
    .ctl_dq_oe(lnk.ctl_dq_oe), .dev_dq_oe(lnk.dev_dq_oe));
  always #4 pclk = ~pclk;
  // count captured write beats
  always @(posedge pclk)
    if (wr_beat === 1'h1)
      beats++;
  // ************************************************************
  // tasks
  // ************************************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // burst chop expected from the burst field and a12
  function automatic logic exp_chop(input logic [1:0] bl, input logic a);
    exp_chop = (bl == 2'h2) || (bl == 2'h1 && !a);
  endfunction : exp_chop
  // one apb transfer, result in rd and err
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // one idle edge so the next setup never reassigns psel in this step
    @(posedge pclk);
  endtask : apb
  // issue a link order and wait until it is done
  task automatic cmd(input logic [3:0] op, input logic [2:0] b, input logic [15:0] a);
    apb(1'h1, dbw_pkg::REG_CMD, {a, 9'h000, b, op});
    do apb(1'h0, dbw_pkg::REG_STATUS, 32'h0); while (rd[0] !== 1'h0);
  endtask : cmd
  task automatic end_sim();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  // ************************************************************
  // sequence
  // ************************************************************
  initial
  begin
    void'($urandom(79361));
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, 12'h020, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    cmd({1'h0, dbw_pkg::CMD_ACT}, 3'h1, 16'h0000);
    // every burst field, both a12 values for fields 1 and 2, random data
    for (int i = 0; i < 9; i++)
    begin
      m = 2'(i % 3);
      a12 = (i < 6) ? i[2] : 1'($urandom);
      r12 = 1'($urandom);
      o = 1'($urandom);
      wd = $urandom;
      ch = exp_chop(m, a12);
      rc = exp_chop(m, r12);
      cmd({1'h0, dbw_pkg::CMD_MRS}, 3'h0, {14'h0, m});
      apb(1'h1, dbw_pkg::REG_WDATA, wd);
      apb(1'h1, dbw_pkg::REG_CTRL, {31'h0, o});
      beats = 0;
      cmd({1'h0, dbw_pkg::CMD_WR}, 3'h1, {3'h0, a12, 12'h000});
      chk("term_on", {31'h0, o}, {31'h0, term_on});
      apb(1'h1, dbw_pkg::REG_CTRL, 32'h0);
      chk("write_beats", ch ? 32'h4 : 32'h8, 32'(beats));
      chk("last_beat", {16'h0, wd[31:16]}, {16'h0, wr_data});
      apb(1'h0, dbw_pkg::REG_STATUS, 32'h0);
      chk("status_chop", {31'h0, ch}, {31'h0, rd[3]});
      cmd({1'h0, dbw_pkg::CMD_RD}, 3'h1, {3'h0, r12, 12'h000});
      chk("read_chop", {31'h0, rc}, {31'h0, last_chop});
      apb(1'h0, dbw_pkg::REG_RDATA, 32'h0);
      chk("read_data", wd, rd);
    end
    // power-down refused with no bank open, then accepted
    cmd({1'h0, dbw_pkg::CMD_PRE}, 3'h0, 16'h0400);
    cmd(dbw_pkg::OP_PDE, 3'h0, 16'h0000);
    apb(1'h0, dbw_pkg::REG_STATUS, 32'h0);
    chk("pd_refused", 32'h2, {29'h0, rd[2:1], 1'h0});
    cmd({1'h0, dbw_pkg::CMD_ACT}, 3'h2, 16'h0000);
    cmd(dbw_pkg::OP_PDE, 3'h0, 16'h0000);
    apb(1'h0, dbw_pkg::REG_STATUS, 32'h0);
    chk("pd_taken", 32'h4, {29'h0, rd[2:1], 1'h0});
    repeat (80) @(posedge pclk);
    chk("term_async_in", 32'h1, {31'h0, term_async});
    cmd(dbw_pkg::OP_PDX, 3'h0, 16'h0000);
    repeat (80) @(posedge pclk);
    chk("term_async_out", 32'h0, {31'h0, term_async});
    end_sim();
  end
  // watchdog against a hang
  initial
  begin
    #400000;
    num_errors++;
    end_sim();
  end
endmodule : testbench
`default_nettype wire
